/* imu_consts.vh */
// Constants for the integer multiply unit: decode fields, register map, reset values.
// Assumes big-endian instruction numbering mapped onto Verilog bit [31 - n].
// Contract
// - Older multiply: high half to dest, low to extension
// - Older multiply is extended opcode 107, four forms
// - Older multiply never touches the carry flag
// - Overflow enable: set sticky and too-wide flags
// - Record bit: field zero from extension low word
// - Opcode 73: signed 64x64, upper 64 to dest
// - 64-bit highs illegal on 32-bit implementation
// - Opcode 9: unsigned 64x64 high product
// - Opcode 9 record: signed compare of result
// - 64-bit highs record: below, above, zero, sticky
// - Opcode 75: signed 32x32, upper word to dest
// - Opcode 75 record: flags from result, copy sticky
// - Older ops only old variant; 75 only new
`ifndef IMU_CONSTS_VH
`define IMU_CONSTS_VH

`define IMU_PRIMARY 6'h1F
`define IMU_XO_MUL 9'h06B
`define IMU_XO_HD 9'h049
`define IMU_XO_HDU 9'h009
`define IMU_XO_HW 9'h04B

// Fixed exception register: sticky summary, too wide, carry
`define IMU_XER_SO 31
`define IMU_XER_OV 30
`define IMU_XER_CA 29
`define IMU_XER_MASK 32'hE000_0000

// Condition field zero: below, above, zero, sticky copy
`define IMU_CR_LT 3
`define IMU_CR_GT 2
`define IMU_CR_EQ 1
`define IMU_CR_SO 0

// Wishbone byte offsets
`define IMU_ADR_CTRL 8'h00
`define IMU_ADR_XER 8'h04
`define IMU_ADR_CR0 8'h08
`define IMU_ADR_EXT 8'h0C
`define IMU_ADR_STAT 8'h10
`define IMU_ADR_CLR 8'h14
`define IMU_ADR_EN 8'h18
`define IMU_ADR_RES_LO 8'h1C
`define IMU_ADR_RES_HI 8'h20

`define IMU_CTRL_OLD 0
`define IMU_CTRL_RST 32'h0000_0000
`define IMU_XER_RST 32'h0000_0000
`define IMU_CR0_RST 4'h0
`define IMU_EXT_RST 32'h0000_0000

// Interrupt status bits
`define IMU_EV_ILLEGAL 0
`define IMU_EV_OVF 1
`define IMU_EV_DONE 2
`define IMU_EV_W 3

`endif

/* imu_top.v */
// Integer multiply datapath: older 32x32 with extension register, 64-bit high
// products, signed 32-bit high word, plus a Wishbone classic register slave.
// Assumes decode presents one instruction with its operands per issue pulse.
`timescale 1ns/1ps
`default_nettype none
`include "imu_consts.vh"

module imu_top #(
   parameter IMPL_64 = 1
) (
   input wire core_clk_in,
   input wire rst_in,
   input wire issue_valid_in,
   input wire [31:0] instr_in,
   input wire [63:0] src_a_in,
   input wire [63:0] src_b_in,
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [7:0] wb_adr_in,
   input wire [3:0] wb_sel_in,
   input wire [31:0] wb_dat_in,
   output reg [31:0] wb_dat_out,
   output reg wb_ack_out,
   output reg irq_out,
   output reg dest_we_out,
   output reg [4:0] dest_idx_out,
   output reg [63:0] dest_data_out,
   output reg illegal_out,
   output reg [3:0] cond_field_zero_out,
   output reg [31:0] fixed_exception_out,
   output reg [31:0] ext_product_out
);

   reg [31:0] ctrl_q;
   reg [31:0] xer_q;
   reg [3:0] cr0_q;
   reg [31:0] ext_q;
   reg [`IMU_EV_W-1:0] stat_q;
   reg [`IMU_EV_W-1:0] en_q;
   reg [63:0] res_q;

   // Decode fields, big-endian bit n sits at Verilog bit 31-n
   // Source index fields are not needed: decode hands over the operands already read
   wire prim_ok;
   wire [8:0] xo;
   wire oe_bit;
   wire record_bit;
   wire old_variant;
   assign prim_ok = (instr_in[31:26] == `IMU_PRIMARY);
   assign xo = instr_in[9:1];
   assign oe_bit = instr_in[10];
   assign record_bit = instr_in[0];
   assign old_variant = ctrl_q[`IMU_CTRL_OLD];

   // A 32-bit build keeps the wide multipliers; only decode refuses the ops
   wire impl64;
   assign impl64 = (IMPL_64 != 0);

   wire op_mul;
   wire op_hd;
   wire op_hdu;
   wire op_hw;
   assign op_mul = prim_ok && (xo == `IMU_XO_MUL) && old_variant;
   assign op_hd = prim_ok && (xo == `IMU_XO_HD) && impl64;
   assign op_hdu = prim_ok && (xo == `IMU_XO_HDU) && impl64;
   assign op_hw = prim_ok && (xo == `IMU_XO_HW) && !old_variant;

   wire legal;
   wire exec;
   wire bad;
   assign legal = op_mul || op_hd || op_hdu || op_hw;
   assign exec = issue_valid_in && legal;
   // Anything else, including 64-bit highs on a 32-bit build, traps
   assign bad = issue_valid_in && !legal;

   // Operands are widened to the product width first, so no multiply pads silently
   wire [63:0] a32_x;
   wire [63:0] b32_x;
   wire [127:0] a64_sx;
   wire [127:0] b64_sx;
   wire [127:0] a64_ux;
   wire [127:0] b64_ux;
   assign a32_x = {{32{src_a_in[31]}}, src_a_in[31:0]};
   assign b32_x = {{32{src_b_in[31]}}, src_b_in[31:0]};
   assign a64_sx = {{64{src_a_in[63]}}, src_a_in};
   assign b64_sx = {{64{src_b_in[63]}}, src_b_in};
   assign a64_ux = {{64{1'b0}}, src_a_in};
   assign b64_ux = {{64{1'b0}}, src_b_in};

   // Products; the two 64-bit ones are large, which is the cost of one-cycle issue
   wire signed [63:0] p32s;
   wire signed [127:0] p64s;
   wire [127:0] p64u;
   assign p32s = $signed(a32_x) * $signed(b32_x);
   assign p64s = $signed(a64_sx) * $signed(b64_sx);
   assign p64u = a64_ux * b64_ux;

   // Product does not fit 32 signed bits when the high word is not a sign fill
   wire ovf32;
   assign ovf32 = (p32s[63:32] != {32{p32s[31]}});

   reg [63:0] res_d;
   reg [63:0] cmp_v;
   reg so_d;
   reg ov_hit;
   reg lt_d;
   reg gt_d;
   reg eq_d;

   always @* begin
      res_d = 64'h0000_0000_0000_0000;
      cmp_v = 64'h0000_0000_0000_0000;
      ov_hit = 1'b0;
      if (op_mul) begin
         // High word to dest, low word compared for field zero
         res_d = {{32{p32s[63]}}, p32s[63:32]};
         cmp_v = {{32{p32s[31]}}, p32s[31:0]};
         ov_hit = oe_bit && ovf32;
      end else if (op_hd) begin
         res_d = p64s[127:64];
         cmp_v = p64s[127:64];
      end else if (op_hdu) begin
         res_d = p64u[127:64];
         cmp_v = p64u[127:64];
      end else if (op_hw) begin
         res_d = {{32{p32s[63]}}, p32s[63:32]};
         cmp_v = {{32{p32s[63]}}, p32s[63:32]};
      end
      so_d = xer_q[`IMU_XER_SO] | ov_hit;
      // Signed compare with zero for every form, unsigned one included
      lt_d = cmp_v[63];
      eq_d = (cmp_v == 64'h0000_0000_0000_0000);
      gt_d = !lt_d && !eq_d;
   end

   // Wishbone classic slave: answer one cycle after the strobe, drop next cycle
   wire bus_req;
   wire bus_wr;
   // The ack term stops a held strobe from being taken a second time
   assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign bus_wr = bus_req && wb_we_in;

   wire [31:0] bmask;
   assign bmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                   {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [31:0] m;
      begin
         merge = (old_v & ~m) | (new_v & m);
      end
   endfunction

   wire wr_ctrl;
   wire wr_xer;
   wire wr_cr0;
   wire wr_ext;
   wire wr_clr;
   wire wr_en;
   assign wr_ctrl = bus_wr && (wb_adr_in == `IMU_ADR_CTRL);
   assign wr_xer = bus_wr && (wb_adr_in == `IMU_ADR_XER);
   assign wr_cr0 = bus_wr && (wb_adr_in == `IMU_ADR_CR0);
   assign wr_ext = bus_wr && (wb_adr_in == `IMU_ADR_EXT);
   assign wr_clr = bus_wr && (wb_adr_in == `IMU_ADR_CLR);
   assign wr_en = bus_wr && (wb_adr_in == `IMU_ADR_EN);

   // Clear register and unmapped offsets read as zero
   reg [31:0] rd_d;
   always @* begin
      case (wb_adr_in)
         `IMU_ADR_CTRL: rd_d = ctrl_q;
         `IMU_ADR_XER: rd_d = xer_q;
         `IMU_ADR_CR0: rd_d = {28'h000_0000, cr0_q};
         `IMU_ADR_EXT: rd_d = ext_q;
         `IMU_ADR_STAT: rd_d = {29'h0000_0000, stat_q};
         `IMU_ADR_EN: rd_d = {29'h0000_0000, en_q};
         `IMU_ADR_RES_LO: rd_d = res_q[31:0];
         `IMU_ADR_RES_HI: rd_d = res_q[63:32];
         default: rd_d = 32'h0000_0000;
      endcase
   end

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack_out <= bus_req;
         wb_dat_out <= (bus_req && !wb_we_in) ? rd_d : 32'h0000_0000;
      end
   end

   // Control and architectural state; an issued op wins over a bus write
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         ctrl_q <= `IMU_CTRL_RST;
      end else if (wr_ctrl) begin
         // Only the variant bit is kept; other control bits read back as zero
         ctrl_q <= merge(ctrl_q, wb_dat_in, bmask) & 32'h0000_0001;
      end
   end

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         xer_q <= `IMU_XER_RST;
      end else if (exec && op_mul && oe_bit) begin
         // Carry bit is never written here
         xer_q[`IMU_XER_SO] <= so_d;
         xer_q[`IMU_XER_OV] <= ov_hit;
      end else if (wr_xer) begin
         xer_q <= merge(xer_q, wb_dat_in, bmask) & `IMU_XER_MASK;
      end
   end

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         cr0_q <= `IMU_CR0_RST;
      end else if (exec && record_bit) begin
         // Only record forms touch the field; with the bit clear it is left alone
         cr0_q[`IMU_CR_LT] <= lt_d;
         cr0_q[`IMU_CR_GT] <= gt_d;
         cr0_q[`IMU_CR_EQ] <= eq_d;
         cr0_q[`IMU_CR_SO] <= so_d;
      end else if (wr_cr0 && wb_sel_in[0]) begin
         // Software writes need byte lane zero
         cr0_q <= wb_dat_in[3:0];
      end
   end

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         ext_q <= `IMU_EXT_RST;
      end else if (exec && op_mul) begin
         ext_q <= p32s[31:0];
      end else if (wr_ext) begin
         ext_q <= merge(ext_q, wb_dat_in, bmask);
      end
   end

   // Sticky events: a new event in the clearing cycle survives
   wire [`IMU_EV_W-1:0] ev;
   assign ev[`IMU_EV_ILLEGAL] = bad;
   assign ev[`IMU_EV_OVF] = exec && ov_hit;
   assign ev[`IMU_EV_DONE] = exec;

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         stat_q <= {`IMU_EV_W{1'b0}};
         en_q <= {`IMU_EV_W{1'b0}};
         irq_out <= 1'b0;
      end else begin
         if (wr_clr && wb_sel_in[0]) begin
            stat_q <= (stat_q & ~wb_dat_in[`IMU_EV_W-1:0]) | ev;
         end else begin
            stat_q <= stat_q | ev;
         end
         if (wr_en && wb_sel_in[0]) begin
            en_q <= wb_dat_in[`IMU_EV_W-1:0];
         end
         // Follows status one cycle late so the pin stays a plain flop
         irq_out <= |(stat_q & en_q);
      end
   end

   // Writeback to the register file and exception port
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         dest_we_out <= 1'b0;
         dest_idx_out <= 5'h00;
         dest_data_out <= 64'h0000_0000_0000_0000;
         illegal_out <= 1'b0;
         res_q <= 64'h0000_0000_0000_0000;
      end else begin
         dest_we_out <= exec;
         illegal_out <= bad;
         // Index and data hold until the next legal op; a trapped one leaves them
         if (exec) begin
            dest_idx_out <= instr_in[25:21];
            dest_data_out <= res_d;
            res_q <= res_d;
         end
      end
   end

   // Mirrors of architectural state for the core
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         cond_field_zero_out <= `IMU_CR0_RST;
         fixed_exception_out <= `IMU_XER_RST;
         ext_product_out <= `IMU_EXT_RST;
      end else begin
         cond_field_zero_out <= cr0_q;
         fixed_exception_out <= xer_q;
         ext_product_out <= ext_q;
      end
   end

endmodule // imu_top
`default_nettype wire

/* imu_checker.sv */
// Checker for the multiply unit; sees only the top-level ports.
// Assumes it is bound to imu_top and given the same IMPL_64.
`timescale 1ns/1ps
`default_nettype none
`include "imu_consts.vh"
module imu_checker #(parameter IMPL_64 = 1) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic issue_valid_in,
   input wire logic [31:0] instr_in,
   input wire logic [63:0] src_a_in,
   input wire logic [63:0] src_b_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_ack_out,
   input wire logic dest_we_out,
   input wire logic [4:0] dest_idx_out,
   input wire logic [63:0] dest_data_out,
   input wire logic illegal_out,
   input wire logic [3:0] cond_field_zero_out,
   input wire logic [31:0] fixed_exception_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   wire signed [63:0] p_w = $signed(src_a_in[31:0]) * $signed(src_b_in[31:0]);
   wire signed [127:0] p_s = $signed(src_a_in) * $signed(src_b_in);
   wire [127:0] p_u = src_a_in * src_b_in;
   wire [63:0] hw_exp = {{32{p_w[63]}}, p_w[63:32]};
   wire [63:0] hs_exp = p_s[127:64];
   wire [63:0] hu_exp = p_u[127:64];
   wire [4:0] rt = instr_in[25:21];
   wire [8:0] xo = instr_in[9:1];
   wire op = issue_valid_in && instr_in[31:26] == `IMU_PRIMARY;
   a_issue_answer: assert property (issue_valid_in |=> dest_we_out != illegal_out)
      else $error("issue not answered once");
   a_idle_silent: assert property (!issue_valid_in |=> !dest_we_out && !illegal_out)
      else $error("answer without issue");
   a_dest_index: assert property (issue_valid_in ##1 dest_we_out |-> dest_idx_out == $past(rt))
      else $error("wrong destination index");
   a_carry_kept: assert property ((issue_valid_in && !wb_cyc_in ##1 !wb_cyc_in) |=>
      $stable(fixed_exception_out[29])) else $error("carry flag changed");
   a_norec_kept: assert property ((op && !instr_in[0] && !wb_cyc_in ##1 !wb_cyc_in) |=>
      $stable(cond_field_zero_out)) else $error("field zero changed");
   a_word_high: assert property (op && xo == `IMU_XO_HW |=> illegal_out ||
      dest_data_out == $past(hw_exp)) else $error("high word wrong");
   a_dbl_signed: assert property (op && xo == `IMU_XO_HD |=> illegal_out ||
      dest_data_out == $past(hs_exp)) else $error("signed high wrong");
   a_dbl_unsigned: assert property (op && xo == `IMU_XO_HDU |=> illegal_out ||
      dest_data_out == $past(hu_exp)) else $error("unsigned high wrong");
   a_narrow_illegal: assert property (op && IMPL_64 == 0 &&
      (xo == `IMU_XO_HD || xo == `IMU_XO_HDU) |=> illegal_out) else $error("wide op ran");
   a_ack_once: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
      else $error("bus ack not a single pulse");
   cover property (op && xo == `IMU_XO_MUL ##1 dest_we_out);
   cover property (issue_valid_in ##1 illegal_out);
   cover property (wb_cyc_in && wb_stb_in ##1 wb_ack_out);
endmodule // imu_checker
`default_nettype wire

/* imu_decode_model.sv */
// Decode-side model: issues one instruction with its operands.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module imu_decode_model (
   input wire logic clk_in,
   output logic issue_valid_out,
   output logic [31:0] instr_out,
   output logic [63:0] src_a_out,
   output logic [63:0] src_b_out
);
   initial begin
      issue_valid_out = 1'b0;
      instr_out = 32'h0000_0000;
      src_a_out = 64'h0;
      src_b_out = 64'h0;
   end
   task automatic issue(input logic [31:0] i, input logic [63:0] a, input logic [63:0] b);
      issue_valid_out <= 1'b1;
      instr_out <= i;
      src_a_out <= a;
      src_b_out <= b;
      @(posedge clk_in);
      issue_valid_out <= 1'b0;
      // Stale fields are scrambled so nothing leans on them
      instr_out <= ~i;
      src_a_out <= ~a;
      src_b_out <= ~b;
   endtask
endmodule // imu_decode_model
`default_nettype wire

/* integer_multiply_unit_test.sv */
// Self-checking bench for the multiply unit with its register slave.
// Assumes the decode model drives the instruction port.
`timescale 1ns/1ps
`default_nettype none
`include "imu_consts.vh"
module integer_multiply_unit_test;
   logic core_clk_in, rst_in, cyc, stb, we, we_s, ill_s, ill_n_s;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rd;
   logic [63:0] res_s;
   int num_errors, n_tests;
   wire issue_valid, wb_ack_out, irq_out, dest_we_out, illegal_out, narrow_ill;
   wire [31:0] instr, wb_dat_out, fixed_exception_out, ext_product_out;
   wire [63:0] src_a, src_b, dest_data_out;
   wire [4:0] dest_idx_out;
   wire [3:0] cond_field_zero_out;
   imu_decode_model u_imu_decode_model (.clk_in(core_clk_in), .issue_valid_out(issue_valid),
      .instr_out(instr), .src_a_out(src_a), .src_b_out(src_b));
   imu_top u_imu_top (.core_clk_in(core_clk_in), .rst_in(rst_in), .issue_valid_in(issue_valid),
      .instr_in(instr), .src_a_in(src_a), .src_b_in(src_b), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
      .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .irq_out(irq_out),
      .dest_we_out(dest_we_out), .dest_idx_out(dest_idx_out), .dest_data_out(dest_data_out),
      .illegal_out(illegal_out), .cond_field_zero_out(cond_field_zero_out),
      .fixed_exception_out(fixed_exception_out), .ext_product_out(ext_product_out));
   // A 32-bit build fed the same stream must trap the wide ops
   imu_top #(.IMPL_64(0)) u_imu_top_narrow (.core_clk_in(core_clk_in), .rst_in(rst_in),
      .issue_valid_in(issue_valid), .instr_in(instr), .src_a_in(src_a), .src_b_in(src_b),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
      .wb_dat_in(wdat), .wb_dat_out(), .wb_ack_out(), .irq_out(), .dest_we_out(),
      .dest_idx_out(), .dest_data_out(), .illegal_out(narrow_ill), .cond_field_zero_out(),
      .fixed_exception_out(), .ext_product_out());
   task automatic final_report;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk_in);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      n = 0;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (wb_ack_out !== 1'b1 && n < 16);
      rd = wb_dat_out;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (wb_ack_out !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t bus timeout", $time);
         final_report();
      end
   endtask
   // Pulses are sampled half a cycle after the taking edge, mirrors a cycle later
   task automatic run(input logic [8:0] xo, input logic oe, input logic rc,
      input logic [63:0] a, input logic [63:0] b);
      @(posedge core_clk_in);
      u_imu_decode_model.issue({`IMU_PRIMARY, 5'h06, 10'h000, oe, xo, rc}, a, b);
      @(negedge core_clk_in);
      we_s = dest_we_out;
      ill_s = illegal_out;
      ill_n_s = narrow_ill;
      res_s = dest_data_out;
      @(negedge core_clk_in);
   endtask
   task automatic t_new_variant;
      run(`IMU_XO_HW, 1'b0, 1'b1, 64'h4500, 64'h8000_7000);
      chk(we_s, 1'b1);
      chk(res_s, 64'hFFFF_FFFF_FFFF_DD80);
      chk(dest_idx_out, 64'h0000_0000_0000_0006);
      chk(cond_field_zero_out, 4'h8);
      run(`IMU_XO_MUL, 1'b1, 1'b1, 64'h3, 64'h2);
      chk(ill_s, 1'b1);
      run(`IMU_XO_HD, 1'b0, 1'b0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h2);
      chk(res_s, 64'hFFFF_FFFF_FFFF_FFFF);
      chk(ill_n_s, 1'b1);
      chk(cond_field_zero_out, 4'h8);
      run(`IMU_XO_HDU, 1'b0, 1'b1, 64'hFFFF_FFFF_FFFF_FFFF, 64'h2);
      chk(res_s, 64'h1);
      chk(ill_n_s, 1'b1);
      chk(cond_field_zero_out, 4'h4);
   endtask
   task automatic t_old_variant;
      wb(1'b1, `IMU_ADR_CTRL, 32'h0000_0001);
      wb(1'b1, `IMU_ADR_XER, 32'h2000_0000);
      wb(1'b1, `IMU_ADR_EN, 32'h0000_0002);
      run(`IMU_XO_HW, 1'b0, 1'b0, 64'h3, 64'h2);
      chk(ill_s, 1'b1);
      chk(irq_out, 1'b0);
      run(`IMU_XO_MUL, 1'b0, 1'b0, 64'h3, 64'h2);
      chk(res_s, 64'h0);
      chk(ext_product_out, 32'h0000_0006);
      chk(fixed_exception_out, 32'h2000_0000);
      run(`IMU_XO_MUL, 1'b1, 1'b1, 64'h4500, 64'h8000_7000);
      chk(res_s, 64'hFFFF_FFFF_FFFF_DD80);
      chk(ext_product_out, 32'h1E30_0000);
      chk(fixed_exception_out, 32'hE000_0000);
      chk(cond_field_zero_out, 4'h5);
      chk(irq_out, 1'b1);
      wb(1'b1, `IMU_ADR_CLR, 32'h0000_0002);
      wb(1'b0, `IMU_ADR_STAT, 32'h0000_0000);
      chk(rd[1], 1'b0);
      chk(irq_out, 1'b0);
      wb(1'b0, 8'h40, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
   endtask
   initial begin
      core_clk_in = 1'b0;
      forever #12.5 core_clk_in = ~core_clk_in;
   end
   initial begin
      rst_in = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hF;
      wdat = 32'h0000_0000; rd = 32'h0000_0000; num_errors = 0; n_tests = 0;
      repeat (20) @(posedge core_clk_in);
      rst_in <= 1'b0;
      t_new_variant();
      t_old_variant();
      final_report();
   end
endmodule // integer_multiply_unit_test
bind imu_top imu_checker #(.IMPL_64(IMPL_64)) u_imu_checker (.core_clk_in(core_clk_in),
   .rst_in(rst_in), .issue_valid_in(issue_valid_in), .instr_in(instr_in),
   .src_a_in(src_a_in), .src_b_in(src_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
   .wb_ack_out(wb_ack_out), .dest_we_out(dest_we_out), .dest_idx_out(dest_idx_out),
   .dest_data_out(dest_data_out), .illegal_out(illegal_out),
   .cond_field_zero_out(cond_field_zero_out), .fixed_exception_out(fixed_exception_out));
`default_nettype wire
